//--- design/timer_pwm_consts.svh
`ifndef TIMER_PWM_CONSTS_SVH
`define TIMER_PWM_CONSTS_SVH

// Register byte offsets on the APB
`define OFS_MODE      8'h00
`define OFS_CTRLB     8'h04
`define OFS_RUN       8'h08
`define OFS_TPS       8'h0c
`define OFS_CNT_A     8'h10
`define OFS_RLD_A     8'h14
`define OFS_STRIDE    8'h08

// Control register B fields
`define CB_PWM_A      6
`define CB_PSC_A_LO   0
`define CB_PSC_STRIDE 3
`define PSC_W         3
`define PSC_MAX       3'd7

// Mode register fields, timer a in the low nibble
`define MD_MODE_LO    0
`define MD_CT_A       2
`define MD_GATE_A     3
`define MD_STRIDE     4
`define MODE_W        2

// Run and flag register fields
`define RN_RUN_LO     0
`define RN_FLAG_LO    4

// Reset values and byte constants
`define CTRLB_RST     8'h24
`define MODE_RST      8'h00
`define BYTE_ZERO     8'h00
`define BYTE_FULL     8'hff
`define BYTE_ONE      8'h01
`define TPS_ZERO      4'h0
`define TPS_ONE       4'h1

`endif

//--- design/timer_pwm_pkg.sv
package timer_pwm_pkg;

	// Per-timer PWM variant, in mode-field order
	typedef enum logic [1:0] {
		VAR_PRESCALE_LOG,
		VAR_PRESCALE_LIN,
		VAR_FREQ_GEN,
		VAR_SPLIT
	} pwm_variant_t;

	typedef logic [7:0] byte_t;

endpackage

//--- design/timer_pwm_modes.sv
`timescale 1ns/1ps
`include "timer_pwm_consts.svh"
// Notes on behaviour
// RULE_01 - Each timer becomes 8-bit PWM when enabled
// RULE_02 - PWM waveform drives the timer pin
// RULE_03 - Software selects timer operation, pin as output
// RULE_04 - Overflow flags and baud tick keep working
// RULE_05 - Gate input can halt the generator
// RULE_06 - Mode field picks one of four variants
// RULE_07 - High at count zero, low at compare
// RULE_08 - Duty shadow loads only on counter wrap
// RULE_09 - Duty zero keeps output low
// RULE_10 - Variant 0 low byte is log prescaler
// RULE_11 - Overflow loads shadow, sets pin; match clears
// RULE_12 - Variant 1 low byte reloads, prescales linearly
// RULE_13 - Variant 2 toggles pin on low overflow
// RULE_14 - Variant 2 ignores both reload registers
// RULE_15 - Timer b in variant 3 holds count
// RULE_16 - Timer a variant 3 splits into two counters
// RULE_17 - Split bytes use timer a, b controls
// RULE_18 - Low reload sets low duty, high sets high
// RULE_19 - Timer b stops only in own variant 3
// RULE_20 - Prescale select is active bits minus one
// RULE_21 - Common prescaler divides every counter tick; pin edges counted outside PWM bypass it
module timer_pwm_modes
	import timer_pwm_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        timer_a_pin_i,
	input  wire logic        timer_b_pin_i,
	input  wire logic        gate_input_pin_a,
	input  wire logic        gate_input_pin_b,
	output logic             timer_a_pin_o,
	output logic             timer_a_pin_oe_n,
	output logic             timer_b_pin_o,
	output logic             timer_b_pin_oe_n,
	output logic             overflow_flag_timer_a,
	output logic             overflow_flag_timer_b,
	output logic             baud_tick
);

	logic [7:0]   timer_mode_reg_ff;
	logic [7:0]   timer_control_b_reg_ff;
	logic [3:0]   common_timer_prescale_ff;
	logic [3:0]   tps_cnt_ff;
	logic [1:0]   run_ff;
	logic [1:0]   flag_ff;
	logic [1:0]   pin_prev_ff;
	logic [1:0]   pin_ff;
	logic [1:0]   oe_n_ff;
	logic         baud_ff;
	logic [31:0]  prdata_ff;
	logic         pready_ff;
	logic         pslverr_ff;
	byte_t        low_count_byte_ff [2];
	byte_t        high_count_byte_ff [2];
	byte_t        low_reload_byte_ff [2];
	byte_t        high_reload_byte_ff [2];
	byte_t        compare_shadow_ff [2];
	byte_t        nxt_tl [2];
	byte_t        nxt_th [2];
	byte_t        dval_ch [2];
	byte_t        cnt_ch [2];
	pwm_variant_t var_m [2];
	logic [1:0]   pe;
	logic [1:0]   gate_ok;
	logic [1:0]   cp;
	logic [1:0]   run_lo;
	logic [1:0]   run_hi;
	logic [1:0]   lo_ovf;
	logic [1:0]   hi_ovf;
	logic [1:0]   th_adv;
	logic [1:0]   tl_adv;
	logic [1:0]   ovf_ev;
	logic [1:0]   wrap_ch;
	logic [1:0]   tog_ch;
	logic [1:0]   adv_ch;
	logic [1:0]   hit_ch;
	logic [1:0]   pin_in;
	logic [1:0]   gate_pin;
	logic         split;
	logic         own_b_ovf;
	logic [1:0]   flag_clr;
	logic         tick;
	logic         wr_en;
	logic         rd_acc;
	logic [31:0]  rd_data;
	logic         rd_err;

	assign pin_in   = {timer_b_pin_i, timer_a_pin_i};
	assign gate_pin = {gate_input_pin_b, gate_input_pin_a};

	// Outputs come straight from flops
	assign prdata                = prdata_ff;
	assign pready                = pready_ff;
	assign pslverr               = pslverr_ff;
	assign timer_a_pin_o         = pin_ff[0];
	assign timer_b_pin_o         = pin_ff[1];
	assign timer_a_pin_oe_n      = oe_n_ff[0];
	assign timer_b_pin_oe_n      = oe_n_ff[1];
	assign overflow_flag_timer_a = flag_ff[0];
	assign overflow_flag_timer_b = flag_ff[1];
	assign baud_tick             = baud_ff;

	// Bus strobes; a write lands on the edge that sees pready high
	assign rd_acc = ce & psel & penable & ~pready_ff;
	assign wr_en  = ce & psel & penable & pwrite & pready_ff;

	// Common prescaler tick, shared by both timers
	assign tick = (tps_cnt_ff == common_timer_prescale_ff); // see RULE_21

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			tps_cnt_ff <= `TPS_ZERO;
		else if (ce)
			tps_cnt_ff <= tick ? `TPS_ZERO : tps_cnt_ff + `TPS_ONE;
	end

	// Split arrangement: timer a low byte on a's controls, high byte on b's
	assign split     = (var_m[0] == VAR_SPLIT); // see RULE_16
	assign run_lo[0] = run_ff[0] & gate_ok[0]; // see RULE_17
	assign run_hi[0] = split ? run_ff[1] : run_lo[0]; // see RULE_17
	// Timer b in its variant 3 behaves as if its run bit were clear
	assign run_lo[1] = run_ff[1] & gate_ok[1] & (var_m[1] != VAR_SPLIT); // see RULE_15
	assign run_hi[1] = run_lo[1]; // see RULE_19

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_timer
			logic [2:0] psc;
			byte_t      mask;
			logic       carry;
			logic       cnt_wr;

			assign var_m[i] = pwm_variant_t'(
				timer_mode_reg_ff[`MD_MODE_LO + `MD_STRIDE * i +: `MODE_W]); // see RULE_06
			assign pe[i] = timer_control_b_reg_ff[`CB_PWM_A + i]; // see RULE_01
			assign psc = timer_control_b_reg_ff[`CB_PSC_A_LO + `CB_PSC_STRIDE * i +: `PSC_W];
			// Gate stays in force in PWM operation
			assign gate_ok[i] = ~timer_mode_reg_ff[`MD_GATE_A + `MD_STRIDE * i]
				| gate_pin[i]; // see RULE_05
			// Pin is only counted when not driving the waveform
			assign cp[i] = (timer_mode_reg_ff[`MD_CT_A + `MD_STRIDE * i] & ~pe[i])
				? (pin_prev_ff[i] & ~pin_in[i]) : tick; // see RULE_02 see RULE_03
			assign cnt_wr = wr_en & (paddr == 8'(`OFS_CNT_A + `OFS_STRIDE * i));

			// Counter next state per variant
			always_comb
			begin
				mask      = `BYTE_FULL >> (`PSC_MAX - psc); // see RULE_20
				carry     = 1'b0;
				lo_ovf[i] = 1'b0;
				nxt_tl[i] = low_count_byte_ff[i];
				nxt_th[i] = high_count_byte_ff[i];
				tl_adv[i] = run_lo[i] & cp[i];
				if (tl_adv[i])
				begin
					case (var_m[i])
						VAR_PRESCALE_LOG:
						begin
							carry     = ((low_count_byte_ff[i] & mask) == mask); // see RULE_10
							nxt_tl[i] = (low_count_byte_ff[i] + `BYTE_ONE) & mask;
						end
						VAR_PRESCALE_LIN:
						begin
							carry     = (low_count_byte_ff[i] == `BYTE_FULL);
							nxt_tl[i] = carry ? low_reload_byte_ff[i]
								: low_count_byte_ff[i] + `BYTE_ONE; // see RULE_12
						end
						VAR_FREQ_GEN:
						begin
							// Reload from the high byte, reload registers unused
							lo_ovf[i] = (low_count_byte_ff[i] == `BYTE_FULL);
							nxt_tl[i] = lo_ovf[i] ? high_count_byte_ff[i]
								: low_count_byte_ff[i] + `BYTE_ONE; // see RULE_13 see RULE_14
						end
						default:
						begin
							lo_ovf[i] = (low_count_byte_ff[i] == `BYTE_FULL);
							nxt_tl[i] = low_count_byte_ff[i] + `BYTE_ONE; // see RULE_16
						end
					endcase
				end
				// Split high byte is a plain timer on the common tick
				th_adv[i] = (var_m[i] == VAR_SPLIT) ? (run_hi[i] & tick) : carry; // see RULE_17
				hi_ovf[i] = th_adv[i] & (high_count_byte_ff[i] == `BYTE_FULL);
				if (th_adv[i])
					nxt_th[i] = high_count_byte_ff[i] + `BYTE_ONE;
			end

			// Software writes to the count win over counting
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					low_count_byte_ff[i]  <= `BYTE_ZERO;
					high_count_byte_ff[i] <= `BYTE_ZERO;
				end
				else if (cnt_wr)
				begin
					low_count_byte_ff[i]  <= pwdata[7:0];
					high_count_byte_ff[i] <= pwdata[15:8];
				end
				else if (ce)
				begin
					low_count_byte_ff[i]  <= nxt_tl[i];
					high_count_byte_ff[i] <= nxt_th[i];
				end
			end

			// Waveform: toggle, set on wrap with shadow load, clear on match
			assign hit_ch[i] = adv_ch[i] & (cnt_ch[i] == compare_shadow_ff[i]);
			always_ff @(posedge clk or posedge reset)
			begin
				if (reset)
				begin
					pin_ff[i]            <= 1'b0;
					oe_n_ff[i]           <= 1'b1;
					compare_shadow_ff[i] <= `BYTE_ZERO;
					pin_prev_ff[i]       <= 1'b0;
				end
				else if (ce)
				begin
					oe_n_ff[i]     <= ~pe[i]; // see RULE_02
					pin_prev_ff[i] <= pin_in[i];
					if (wrap_ch[i])
						compare_shadow_ff[i] <= dval_ch[i]; // see RULE_08 see RULE_11
					if (!pe[i])
						pin_ff[i] <= 1'b0;
					else if (tog_ch[i])
						pin_ff[i] <= ~pin_ff[i]; // see RULE_13
					else if (wrap_ch[i])
						pin_ff[i] <= (dval_ch[i] != `BYTE_ZERO); // see RULE_07 see RULE_09
					else if (hit_ch[i])
						pin_ff[i] <= 1'b0; // see RULE_07 see RULE_11
				end
			end
		end
	endgenerate

	// Channel a: low byte in split, else the high byte
	assign wrap_ch[0] = split ? lo_ovf[0]
		: (var_m[0] != VAR_FREQ_GEN) & hi_ovf[0]; // see RULE_11
	assign tog_ch[0]  = (var_m[0] == VAR_FREQ_GEN) & lo_ovf[0];
	assign adv_ch[0]  = split ? tl_adv[0] : th_adv[0];
	assign cnt_ch[0]  = split ? nxt_tl[0] : nxt_th[0];
	assign dval_ch[0] = split ? low_reload_byte_ff[0] : high_reload_byte_ff[0]; // see RULE_18

	// Channel b: taken over by timer a's high byte while split
	assign wrap_ch[1] = split ? hi_ovf[0]
		: (var_m[1] < VAR_FREQ_GEN) & hi_ovf[1];
	assign tog_ch[1]  = ~split & (var_m[1] == VAR_FREQ_GEN) & lo_ovf[1];
	assign adv_ch[1]  = split ? th_adv[0] : th_adv[1];
	assign cnt_ch[1]  = split ? nxt_th[0] : nxt_th[1];
	assign dval_ch[1] = high_reload_byte_ff[split ? 0 : 1]; // see RULE_18

	// Overflow events; timer b's own overflow still feeds the baud tick
	assign ovf_ev[0] = (split | (var_m[0] == VAR_FREQ_GEN)) ? lo_ovf[0] : hi_ovf[0];
	assign own_b_ovf = (var_m[1] == VAR_FREQ_GEN) ? lo_ovf[1] : hi_ovf[1];
	assign ovf_ev[1] = split ? hi_ovf[0] : own_b_ovf; // see RULE_17

	// Sticky flags, write one to clear; a same-cycle event wins
	assign flag_clr = (wr_en & (paddr == `OFS_RUN)) ? pwdata[`RN_FLAG_LO +: 2] : 2'b00;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			flag_ff <= 2'b00;
			baud_ff <= 1'b0;
		end
		else if (ce)
		begin
			flag_ff <= (flag_ff & ~flag_clr) | ovf_ev; // see RULE_04
			baud_ff <= own_b_ovf; // see RULE_04 see RULE_19
		end
	end

	// Configuration registers written by software
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			timer_mode_reg_ff        <= `MODE_RST;
			timer_control_b_reg_ff   <= `CTRLB_RST; // see RULE_20
			common_timer_prescale_ff <= `TPS_ZERO;
			run_ff                   <= 2'b00;
			low_reload_byte_ff[0]    <= `BYTE_ZERO;
			high_reload_byte_ff[0]   <= `BYTE_ZERO;
			low_reload_byte_ff[1]    <= `BYTE_ZERO;
			high_reload_byte_ff[1]   <= `BYTE_ZERO;
		end
		else if (wr_en)
		begin
			case (paddr)
				`OFS_MODE:  timer_mode_reg_ff <= pwdata[7:0];
				`OFS_CTRLB: timer_control_b_reg_ff <= pwdata[7:0];
				`OFS_TPS:   common_timer_prescale_ff <= pwdata[3:0];
				`OFS_RUN:   run_ff <= pwdata[`RN_RUN_LO +: 2];
				`OFS_RLD_A:
				begin
					low_reload_byte_ff[0]  <= pwdata[7:0];
					high_reload_byte_ff[0] <= pwdata[15:8];
				end
				`OFS_RLD_A + `OFS_STRIDE:
				begin
					low_reload_byte_ff[1]  <= pwdata[7:0];
					high_reload_byte_ff[1] <= pwdata[15:8];
				end
				default: ;
			endcase
		end
	end

	// Read mux; unmapped addresses read zero with an error
	always_comb
	begin
		rd_err  = 1'b0;
		rd_data = 32'h0000_0000;
		case (paddr)
			`OFS_MODE:  rd_data = {24'h00_0000, timer_mode_reg_ff};
			`OFS_CTRLB: rd_data = {24'h00_0000, timer_control_b_reg_ff};
			`OFS_RUN:   rd_data = {26'h000_0000, flag_ff, 2'b00, run_ff};
			`OFS_TPS:   rd_data = {28'h000_0000, common_timer_prescale_ff};
			`OFS_CNT_A: rd_data = {16'h0000, high_count_byte_ff[0], low_count_byte_ff[0]};
			`OFS_RLD_A: rd_data = {16'h0000, high_reload_byte_ff[0], low_reload_byte_ff[0]};
			`OFS_CNT_A + `OFS_STRIDE:
				rd_data = {16'h0000, high_count_byte_ff[1], low_count_byte_ff[1]};
			`OFS_RLD_A + `OFS_STRIDE:
				rd_data = {16'h0000, high_reload_byte_ff[1], low_reload_byte_ff[1]};
			default: rd_err = 1'b1;
		endcase
	end

	// One wait state: pready rises on the second access cycle
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready_ff  <= rd_acc;
			pslverr_ff <= rd_acc & rd_err;
			prdata_ff  <= (rd_acc & ~pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_pin_driven: assert property (ce && pe[0] |=> !timer_a_pin_oe_n) // see RULE_02
		else $error("pin not driven in pwm");
	a_duty_zero: assert property (ce && pe[0] && wrap_ch[0] && !tog_ch[0]
		&& dval_ch[0] == 8'h00 |=> !timer_a_pin_o) // see RULE_09
		else $error("zero duty drove pin high");
	a_shadow_load: assert property (ce && wrap_ch[0]
		|=> compare_shadow_ff[0] == $past(dval_ch[0])) // see RULE_08
		else $error("shadow not loaded on wrap");
	a_shadow_hold: assert property (!(ce && wrap_ch[1]) |=> $stable(compare_shadow_ff[1])) // see RULE_08
		else $error("shadow changed without wrap");
	a_match_clear: assert property (ce && pe[0] && hit_ch[0] && !wrap_ch[0] && !tog_ch[0]
		|=> !timer_a_pin_o) // see RULE_07
		else $error("match did not clear pin");
	a_flag_set: assert property (ce && ovf_ev[0] // see RULE_04
		|=> overflow_flag_timer_a ##1 (overflow_flag_timer_a || $past(flag_clr[0])))
		else $error("overflow flag lost");
	a_b_hold_split: assert property (ce && var_m[1] == VAR_SPLIT && !wr_en
		|=> $stable(low_count_byte_ff[1])) // see RULE_15
		else $error("timer b counted in variant 3");
	a_gate_halt: assert property (ce && !gate_ok[0] && !wr_en
		|=> $stable(low_count_byte_ff[0])) // see RULE_05
		else $error("gate did not halt timer a");
	a_freq_toggle: assert property (ce && pe[0] && tog_ch[0]
		|=> timer_a_pin_o != $past(timer_a_pin_o)) // see RULE_13
		else $error("pin did not toggle");
	a_apb_wait: assert property (rd_acc |=> pready ##1 !pready) // see RULE_01
		else $error("bus answer timing wrong");

endmodule // timer_pwm_modes

//--- tb/pwm_load.sv
`timescale 1ns/1ps
// Load on both timer pins; measures period and high time seen on the wire
module pwm_load
(
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        drv_a,
	input  wire logic        oe_n_a,
	input  wire logic        drv_b,
	input  wire logic        oe_n_b,
	output logic             wire_a,
	output logic             wire_b,
	output logic      [15:0] hi_a,
	output logic      [15:0] per_a,
	output logic      [15:0] hi_b,
	output logic      [15:0] per_b
);
	logic [1:0]  lvl;
	logic [1:0]  last_ff;
	logic [1:0]  hold_ff;
	logic [15:0] cnt_ff [2];
	logic [15:0] hi_ff  [2];
	logic [15:0] per_ff [2];

	// A released pin holds the inverse of its last driven level, so a stale value never looks driven
	assign lvl    = ({oe_n_b, oe_n_a} & ~hold_ff) | (~{oe_n_b, oe_n_a} & {drv_b, drv_a});
	assign wire_a = lvl[0];
	assign wire_b = lvl[1];
	assign hi_a   = hi_ff[0];
	assign per_a  = per_ff[0];
	assign hi_b   = hi_ff[1];
	assign per_b  = per_ff[1];

	// Cycles since the last rising edge give period at a rise and high time at a fall
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			last_ff <= 2'h0;
			hold_ff <= 2'h0;
			for (int i = 0; i < 2; i++)
			begin
				cnt_ff[i] <= 16'h0;
				hi_ff[i]  <= 16'h0;
				per_ff[i] <= 16'h0;
			end
		end
		else
		begin
			last_ff <= lvl;
			hold_ff <= ({oe_n_b, oe_n_a} & hold_ff) | (~{oe_n_b, oe_n_a} & {drv_b, drv_a});
			for (int i = 0; i < 2; i++)
			begin
				if (lvl[i] & ~last_ff[i])
				begin
					per_ff[i] <= cnt_ff[i];
					cnt_ff[i] <= 16'h1;
				end
				else
					cnt_ff[i] <= cnt_ff[i] + 16'h1;
				if (~lvl[i] & last_ff[i])
					hi_ff[i] <= cnt_ff[i];
			end
		end
	end
endmodule // pwm_load

//--- tb/test_timer_pwm_modes.sv
`timescale 1ns/1ps
`include "timer_pwm_consts.svh"
module test_timer_pwm_modes;
	logic        clk, reset, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q, v;
	logic        e, pa_o, pa_oe_n, pb_o, pb_oe_n, wa, wb, ga, gb, fa, fb, baud;
	logic [15:0] hi_a, per_a, hi_b, per_b;
	int          fails, n_tests, kp, kb;

	timer_pwm_modes i_timer_pwm_modes (.clk(clk), .reset(reset), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_a_pin_i(wa),
		.timer_b_pin_i(wb), .gate_input_pin_a(ga), .gate_input_pin_b(gb),
		.timer_a_pin_o(pa_o), .timer_a_pin_oe_n(pa_oe_n), .timer_b_pin_o(pb_o),
		.timer_b_pin_oe_n(pb_oe_n), .overflow_flag_timer_a(fa),
		.overflow_flag_timer_b(fb), .baud_tick(baud));

	pwm_load i_pwm_load (.clk(clk), .reset(reset), .drv_a(pa_o), .oe_n_a(pa_oe_n),
		.drv_b(pb_o), .oe_n_b(pb_oe_n), .wire_a(wa), .wire_b(wb), .hi_a(hi_a),
		.per_a(per_a), .hi_b(hi_b), .per_b(per_b));

	task automatic finish_test();
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic timeout();
		fails++;
		$display("unexpected at %0t: wait ran out", $time);
		finish_test();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One transfer; the bus idles an edge after it so psel is never driven twice at one edge
	task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		if (n >= 20)
			timeout();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic wait_pin(input logic lv);
		int n;
		n = 0;
		while (pa_o !== lv && n < 600)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 600)
			timeout();
	endtask

	// Counts cycles with pin a high and baud pulses over a window
	task automatic watch(input int n);
		kp = 0;
		kb = 0;
		repeat (n)
		begin
			@(posedge clk);
			if (pa_o !== 1'b0)
				kp++;
			if (baud !== 1'b0)
				kb++;
		end
	endtask

	task automatic t_reset();
		rd(`OFS_CTRLB);
		chk(q, 32'h24);
		rd(`OFS_MODE);
		chk(q, 32'h0);
		chk(32'(pa_oe_n), 32'h1);
		rd(8'h20);
		chk({q[30:0], e}, 32'h1);
	endtask

	task automatic t_var1();
		wr(`OFS_MODE, 32'h01);
		wr(`OFS_RLD_A, 32'h40ff);
		wr(`OFS_CTRLB, 32'h64);
		wr(`OFS_RUN, 32'h01);
		repeat (800) @(posedge clk);
		chk(32'(per_a), 32'h100);
		chk(32'(hi_a), 32'h40);
		chk(32'(pa_oe_n), 32'h0);
		rd(`OFS_RUN);
		chk(q & 32'h10, 32'h10);
		chk(32'(fa), 32'h1);
		wait_pin(1'b0);
		wait_pin(1'b1);
		// New duty lands early in a high phase; it must wait for the wrap
		wr(`OFS_RLD_A, 32'h80ff);
		repeat (200) @(posedge clk);
		chk(32'(hi_a), 32'h40);
		repeat (200) @(posedge clk);
		chk(32'(hi_a), 32'h80);
		wr(`OFS_TPS, 32'h1);
		repeat (1300) @(posedge clk);
		chk(32'(per_a), 32'h200);
		wr(`OFS_TPS, 32'h0);
	endtask

	task automatic t_duty0();
		wr(`OFS_RLD_A, 32'h00ff);
		repeat (300) @(posedge clk);
		watch(300);
		chk(32'(kp), 32'h0);
	endtask

	task automatic t_var0();
		wr(`OFS_MODE, 32'h00);
		wr(`OFS_CTRLB, 32'h40);
		wr(`OFS_RLD_A, 32'h4000);
		repeat (1200) @(posedge clk);
		chk(32'(per_a), 32'h200);
		chk(32'(hi_a), 32'h80);
	endtask

	task automatic t_var2();
		wr(`OFS_MODE, 32'h02);
		wr(`OFS_CNT_A, 32'hf0f0);
		wr(`OFS_RLD_A, 32'h1234);
		repeat (200) @(posedge clk);
		chk(32'(per_a), 32'h20);
		chk(32'(hi_a), 32'h10);
		rd(`OFS_RLD_A);
		chk(q, 32'h1234);
	endtask

	task automatic t_split();
		wr(`OFS_MODE, 32'h03);
		wr(`OFS_RLD_A, 32'h8040);
		wr(`OFS_CTRLB, 32'hc0);
		wr(`OFS_RUN, 32'h33);
		repeat (700) @(posedge clk);
		chk(32'(per_a), 32'h100);
		chk(32'(hi_a), 32'h40);
		chk(32'(per_b), 32'h100);
		chk(32'(hi_b), 32'h80);
		rd(`OFS_RUN);
		chk(q & 32'h20, 32'h20);
		chk(32'(fb), 32'h1);
		chk(32'(pb_oe_n), 32'h0);
		wr(`OFS_CNT_A + `OFS_STRIDE, 32'h0);
		wr(`OFS_MODE, 32'h33);
		rd(`OFS_CNT_A + `OFS_STRIDE);
		v = q;
		repeat (50) @(posedge clk);
		rd(`OFS_CNT_A + `OFS_STRIDE);
		chk(q, v);
		wr(`OFS_MODE, 32'h23);
		watch(600);
		chk(32'(kb), 32'h2);
	endtask

	task automatic t_gate();
		wr(`OFS_MODE, 32'h09);
		ga <= 1'b0;
		rd(`OFS_CNT_A);
		v = q;
		repeat (50) @(posedge clk);
		rd(`OFS_CNT_A);
		chk(q, v);
		ga <= 1'b1;
		repeat (50) @(posedge clk);
		rd(`OFS_CNT_A);
		chk(32'(q !== v), 32'h1);
		// Outside PWM the pin is sampled again; a released pin gives no edges
		wr(`OFS_CTRLB, 32'h80);
		wr(`OFS_MODE, 32'h05);
		rd(`OFS_CNT_A);
		v = q;
		repeat (50) @(posedge clk);
		rd(`OFS_CNT_A);
		chk(q, v);
		chk(32'(pa_oe_n), 32'h1);
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Main sequence; ce stays high since stalling is not a documented behaviour
	initial
	begin
		fails = 0;
		n_tests = 0;
		reset = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		ga = 1'b1;
		gb = 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_var1();
		t_duty0();
		t_var0();
		t_var2();
		t_split();
		t_gate();
		finish_test();
	end
endmodule // test_timer_pwm_modes
